// >>> shared/cbrd_pkg.sv
// Constants, types and opcodes of the decoder
// How it works
// RL1 - 20 always, 21 never, 22 higher, 23 lower-same, 24 carry clear, 25 set
// RL2 - 26/27 zero clear/set, 28/29 half clear/set, 2A/2B minus clear/set
// RL3 - 2C jumps when interrupt mask clear, 2D when mask set
// RL4 - 2E jumps when interrupt pin low, 2F when pin high
// RL5 - Higher-same alias is 24, lower alias is 25; no own opcodes
// RL6 - Relative jumps 20 to 2F are two bytes and three cycles
// RL7 - Relative call AD is two bytes, six cycles, pushes return address
// RL8 - Bit-set test jump is opcode 2n, three bytes, five cycles
// RL9 - Bit-clear test jump is 01+2n; low bit picks polarity
// RL10 - Set bit 10+2n, clear bit 11+2n; two bytes, five cycles
// RL11 - High nibble picks operand: 4 acc, 5 index, 3 direct, 7/6 indexed
// RL12 - Cycles: registers 1/3, direct 2/5, indexed 1/5, offset 2/6
// RL13 - Low nibble picks operation: 0 3 4 6 7 8 9 A C D F
// RL14 - Test op takes 3 on registers, 4 direct, 4 indexed, 5 offset
// RL15 - One-byte two-cycle control: 97 9F 99 98 9C 9D 8E 8F
// RL16 - 9B sets interrupt mask, 9A clears it; one byte, two cycles
// RL17 - Subroutine return 81 is one byte and six cycles
// RL18 - Trap return 80 takes nine cycles; soft trap 83 takes ten
// RL19 - Multiply 42 gives 16-bit product in eleven cycles, clears H and C
// RL20 - Half carry is carry out of bit 3 of last arithmetic result
// RL21 - Jump offset is signed, added to next instruction address
// RL22 - Rmw ops write back their result, except test which only sets flags
package cbrd_pkg;

  // Opcodes and opcode nibbles
  localparam logic [7:0] OP_CALL_REL   = 8'hAD;
  localparam logic [7:0] OP_PRODUCT    = 8'h42;
  localparam logic [7:0] OP_COPY_A2X   = 8'h97;
  localparam logic [7:0] OP_COPY_X2A   = 8'h9F;
  localparam logic [7:0] OP_SET_CARRY  = 8'h99;
  localparam logic [7:0] OP_CLR_CARRY  = 8'h98;
  localparam logic [7:0] OP_MASK       = 8'h9B;
  localparam logic [7:0] OP_UNMASK     = 8'h9A;
  localparam logic [7:0] OP_SOFT_TRAP  = 8'h83;
  localparam logic [7:0] OP_RETURN     = 8'h81;
  localparam logic [7:0] OP_RET_TRAP   = 8'h80;
  localparam logic [7:0] OP_STACK_INIT = 8'h9C;
  localparam logic [7:0] OP_IDLE       = 8'h9D;
  localparam logic [7:0] OP_STOP       = 8'h8E;
  localparam logic [7:0] OP_WAIT       = 8'h8F;
  localparam logic [3:0] NIB_BTB       = 4'h0;
  localparam logic [3:0] NIB_BSC       = 4'h1;
  localparam logic [3:0] NIB_JUMP      = 4'h2;
  localparam logic [3:0] NIB_DIR       = 4'h3;
  localparam logic [3:0] NIB_ACC       = 4'h4;
  localparam logic [3:0] NIB_IDX       = 4'h5;
  localparam logic [3:0] NIB_IX1       = 4'h6;
  localparam logic [3:0] NIB_IX        = 4'h7;

  // Lengths in bytes
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // Cycle counts
  localparam logic [3:0] CYC_CTRL     = 4'h2;
  localparam logic [3:0] CYC_JUMP     = 4'h3;
  localparam logic [3:0] CYC_CALL     = 4'h6;
  localparam logic [3:0] CYC_BIT      = 4'h5;
  localparam logic [3:0] CYC_RMW_REG  = 4'h3;
  localparam logic [3:0] CYC_RMW_DIR  = 4'h5;
  localparam logic [3:0] CYC_RMW_IX   = 4'h5;
  localparam logic [3:0] CYC_RMW_IX1  = 4'h6;
  localparam logic [3:0] CYC_TST_DIR  = 4'h4;
  localparam logic [3:0] CYC_TST_IX   = 4'h4;
  localparam logic [3:0] CYC_TST_IX1  = 4'h5;
  localparam logic [3:0] CYC_PRODUCT  = 4'hB;
  localparam logic [3:0] CYC_RETURN   = 4'h6;
  localparam logic [3:0] CYC_RET_TRAP = 4'h9;
  localparam logic [3:0] CYC_TRAP     = 4'hA;

  typedef enum logic [3:0] {
    CL_NONE, CL_JUMP, CL_CALL, CL_BIT_TEST, CL_BIT_SET, CL_RMW,
    CL_PRODUCT, CL_CTRL, CL_RETURN, CL_RET_TRAP, CL_TRAP, CL_STOP, CL_WAIT
  } cbrd_class_t;

  typedef enum logic [3:0] {
    MD_INH, MD_ACC, MD_IDX, MD_DIR, MD_IX, MD_IX1, MD_REL, MD_BSC, MD_BTB
  } cbrd_mode_t;

  typedef enum logic [3:0] {
    RM_NONE, RM_TWOS, RM_INVERT, RM_SHR, RM_ROR, RM_ASR, RM_SHL, RM_ROL,
    RM_DEC, RM_INC, RM_TEST, RM_ZERO
  } cbrd_rmw_t;

  typedef enum logic [3:0] {
    CT_NONE, CT_COPY_ACC_TO_INDEX, CT_COPY_INDEX_TO_ACC, CT_SET_CARRY,
    CT_CLEAR_CARRY, CT_MASK, CT_UNMASK, CT_STACK_INIT, CT_IDLE
  } cbrd_ctrl_t;

  // Condition code bits
  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } cbrd_ccr_t;

  // One decoded instruction
  typedef struct packed {
    cbrd_class_t cls;
    cbrd_mode_t  mode;
    cbrd_rmw_t   rmw;
    cbrd_ctrl_t  ctrl;
    logic [1:0]  len;
    logic [3:0]  cycles;
    logic        write_back;
  } cbrd_dec_t;

  localparam cbrd_ccr_t CCR_RESET = 5'h04;

endpackage : cbrd_pkg

// >>> logic/cbrd_jump_eval.sv
// Jump condition and relative target
module cbrd_jump_eval
  import cbrd_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic [7:0]        opcode,
  input  wire cbrd_ccr_t         ccr,
  input  wire logic              irq_pin,
  input  wire logic [7:0]        data,
  input  wire logic [7:0]        offset,
  input  wire logic [ADDR_W-1:0] pc,
  input  wire logic [1:0]        len,
  output logic                   taken,
  output logic [ADDR_W-1:0]      target
);

  logic base_flag;

  // Even opcode jumps on flag low, odd on flag high; bit-test opcodes jump on bit high when even, low when odd
  always_comb begin
    unique case (opcode[3:1])
      3'h0: base_flag = 1'b0;             // see RL1
      3'h1: base_flag = ccr.c | ccr.z;    // see RL1
      3'h2: base_flag = ccr.c;            // see RL1, see RL5
      3'h3: base_flag = ccr.z;            // see RL2
      3'h4: base_flag = ccr.h;            // see RL2
      3'h5: base_flag = ccr.n;            // see RL2
      3'h6: base_flag = ccr.i;            // see RL3
      3'h7: base_flag = irq_pin;          // see RL4
    endcase
    if (opcode[7:4] == NIB_BTB) begin
      taken = data[opcode[3:1]] ^ opcode[0]; // see RL8, see RL9
    end else begin
      taken = ~base_flag ^ opcode[0];
    end
  end

  // Next instruction address plus signed offset
  assign target = pc + ADDR_W'(len) + ADDR_W'($signed(offset)); // see RL21

endmodule : cbrd_jump_eval

// >>> logic/cbrd_decoder.sv
// Decoder for jump, bit, rmw, multiply and control opcodes
module cbrd_decoder
  import cbrd_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              MCLK,
  input  wire logic              RST_N,
  input  wire logic              FETCH_VALID,
  input  wire logic [7:0]        FETCH_OPCODE,
  input  wire logic [ADDR_W-1:0] FETCH_PC,
  input  wire logic [7:0]        FETCH_OFFSET,
  input  wire logic [7:0]        FETCH_DATA,
  input  wire logic [7:0]        ACC_IN,
  input  wire logic [7:0]        IDX_IN,
  input  wire logic              IRQ_PIN,
  input  wire logic              ALU_VALID,
  input  wire logic [7:0]        ALU_A,
  input  wire logic [7:0]        ALU_B,
  input  wire logic              ALU_CIN,
  output logic                   DEC_VALID,
  output cbrd_dec_t              DEC_INFO,
  output logic                   JUMP_TAKEN,
  output logic [ADDR_W-1:0]      JUMP_TARGET,
  output logic [7:0]             RESULT,
  output logic [15:0]            PRODUCT,
  output cbrd_ccr_t              CCR,
  output logic                   UNHANDLED
);

  logic [3:0]        hi;
  logic [3:0]        lo;
  cbrd_dec_t         dec;
  logic              bad;
  logic [7:0]        opnd;
  logic [7:0]        res;
  logic              c_out;
  logic [7:0]        bit_mask;
  logic              taken;
  logic [ADDR_W-1:0] target;
  logic [4:0]        low_sum;

  logic              valid_reg;
  logic              valid_next;
  cbrd_dec_t         dec_reg;
  cbrd_dec_t         dec_next;
  logic              taken_reg;
  logic              taken_next;
  logic [ADDR_W-1:0] target_reg;
  logic [ADDR_W-1:0] target_next;
  logic [7:0]        result_reg;
  logic [7:0]        result_next;
  logic [15:0]       product_reg;
  logic [15:0]       product_next;
  cbrd_ccr_t         ccr_reg;
  cbrd_ccr_t         ccr_next;
  logic              bad_reg;
  logic              bad_next;

  assign hi = FETCH_OPCODE[7:4];
  assign lo = FETCH_OPCODE[3:0];

  // Opcode classification, length and cycle count
  always_comb begin
    dec.cls        = CL_NONE;
    dec.mode       = MD_INH;
    dec.rmw        = RM_NONE;
    dec.ctrl       = CT_NONE;
    dec.len        = LEN_1;
    dec.cycles     = CYC_CTRL;
    dec.write_back = 1'b0;
    bad            = 1'b0;
    if (FETCH_OPCODE == OP_CALL_REL) begin
      dec.cls    = CL_CALL;                // see RL7
      dec.mode   = MD_REL;
      dec.len    = LEN_2;
      dec.cycles = CYC_CALL;
    end else if (hi == NIB_JUMP) begin
      dec.cls    = CL_JUMP;                // see RL6
      dec.mode   = MD_REL;
      dec.len    = LEN_2;
      dec.cycles = CYC_JUMP;
    end else if (hi == NIB_BTB) begin
      dec.cls    = CL_BIT_TEST;            // see RL8, see RL9
      dec.mode   = MD_BTB;
      dec.len    = LEN_3;
      dec.cycles = CYC_BIT;
    end else if (hi == NIB_BSC) begin
      dec.cls        = CL_BIT_SET;         // see RL10
      dec.mode       = MD_BSC;
      dec.len        = LEN_2;
      dec.cycles     = CYC_BIT;
      dec.write_back = 1'b1;
    end else if (FETCH_OPCODE == OP_PRODUCT) begin
      dec.cls    = CL_PRODUCT;             // see RL19
      dec.cycles = CYC_PRODUCT;
    end else if (hi >= NIB_DIR && hi <= NIB_IX) begin
      dec.cls = CL_RMW;
      // Operation from low nibble
      unique case (lo)                     // see RL13
        4'h0: dec.rmw = RM_TWOS;
        4'h3: dec.rmw = RM_INVERT;
        4'h4: dec.rmw = RM_SHR;
        4'h6: dec.rmw = RM_ROR;
        4'h7: dec.rmw = RM_ASR;
        4'h8: dec.rmw = RM_SHL;
        4'h9: dec.rmw = RM_ROL;
        4'hA: dec.rmw = RM_DEC;
        4'hC: dec.rmw = RM_INC;
        4'hD: dec.rmw = RM_TEST;
        4'hF: dec.rmw = RM_ZERO;
        default: begin
          dec.cls = CL_NONE;
          bad     = 1'b1;
        end
      endcase
      // Operand, length and cycles from high nibble
      unique case (hi)                     // see RL11, see RL12
        NIB_ACC: begin
          dec.mode   = MD_ACC;
          dec.cycles = CYC_RMW_REG;        // see RL14
        end
        NIB_IDX: begin
          dec.mode   = MD_IDX;
          dec.cycles = CYC_RMW_REG;        // see RL14
        end
        NIB_DIR: begin
          dec.mode   = MD_DIR;
          dec.len    = LEN_2;
          dec.cycles = (dec.rmw == RM_TEST) ? CYC_TST_DIR : CYC_RMW_DIR;
        end
        NIB_IX: begin
          dec.mode   = MD_IX;
          dec.cycles = (dec.rmw == RM_TEST) ? CYC_TST_IX : CYC_RMW_IX;
        end
        default: begin
          dec.mode   = MD_IX1;
          dec.len    = LEN_2;
          dec.cycles = (dec.rmw == RM_TEST) ? CYC_TST_IX1 : CYC_RMW_IX1;
        end
      endcase
      dec.write_back = !bad && dec.rmw != RM_TEST;  // see RL22
      if (bad) begin
        dec.mode   = MD_INH;
        dec.rmw    = RM_NONE;
        dec.len    = LEN_1;
        dec.cycles = CYC_CTRL;
      end
    end else begin
      // Inherent control group
      dec.cls = CL_CTRL;
      unique case (FETCH_OPCODE)
        OP_COPY_A2X:   dec.ctrl = CT_COPY_ACC_TO_INDEX; // see RL15
        OP_COPY_X2A:   dec.ctrl = CT_COPY_INDEX_TO_ACC; // see RL15
        OP_SET_CARRY:  dec.ctrl = CT_SET_CARRY;         // see RL15
        OP_CLR_CARRY:  dec.ctrl = CT_CLEAR_CARRY;       // see RL15
        OP_STACK_INIT: dec.ctrl = CT_STACK_INIT;        // see RL15
        OP_IDLE:       dec.ctrl = CT_IDLE;              // see RL15
        OP_MASK:       dec.ctrl = CT_MASK;              // see RL16
        OP_UNMASK:     dec.ctrl = CT_UNMASK;            // see RL16
        OP_STOP:       dec.cls  = CL_STOP;              // see RL15
        OP_WAIT:       dec.cls  = CL_WAIT;              // see RL15
        OP_RETURN: begin
          dec.cls    = CL_RETURN;                       // see RL17
          dec.cycles = CYC_RETURN;
        end
        OP_RET_TRAP: begin
          dec.cls    = CL_RET_TRAP;                     // see RL18
          dec.cycles = CYC_RET_TRAP;
        end
        OP_SOFT_TRAP: begin
          dec.cls    = CL_TRAP;                         // see RL18
          dec.cycles = CYC_TRAP;
        end
        default: begin
          dec.cls = CL_NONE;
          bad     = 1'b1;
        end
      endcase
    end
  end

  // Rmw operand and operation
  always_comb begin
    unique case (dec.mode)
      MD_ACC:  opnd = ACC_IN;              // see RL11
      MD_IDX:  opnd = IDX_IN;              // see RL11
      default: opnd = FETCH_DATA;
    endcase
    res   = opnd;
    c_out = ccr_reg.c;
    unique case (dec.rmw)
      RM_NONE, RM_TEST: res = opnd;
      RM_TWOS: begin
        res   = 8'h00 - opnd;
        c_out = (opnd != 8'h00);
      end
      RM_INVERT: begin
        res   = ~opnd;
        c_out = 1'b1;
      end
      RM_SHR: begin
        res   = {1'b0, opnd[7:1]};
        c_out = opnd[0];
      end
      RM_ROR: begin
        res   = {ccr_reg.c, opnd[7:1]};
        c_out = opnd[0];
      end
      RM_ASR: begin
        res   = {opnd[7], opnd[7:1]};
        c_out = opnd[0];
      end
      RM_SHL: begin
        res   = {opnd[6:0], 1'b0};
        c_out = opnd[7];
      end
      RM_ROL: begin
        res   = {opnd[6:0], ccr_reg.c};
        c_out = opnd[7];
      end
      RM_DEC:  res = opnd - 8'h01;
      RM_INC:  res = opnd + 8'h01;
      RM_ZERO: res = 8'h00;
    endcase
  end

  // Mask of the opcode's bit number
  assign bit_mask = 8'h01 << FETCH_OPCODE[3:1];

  // Half carry from bit 3
  assign low_sum = {1'b0, ALU_A[3:0]} + {1'b0, ALU_B[3:0]}
                 + {4'h0, ALU_CIN};

  cbrd_jump_eval #(
    .ADDR_W (ADDR_W)
  ) u_jump (
    .opcode  (FETCH_OPCODE),
    .ccr     (ccr_reg),
    .irq_pin (IRQ_PIN),
    .data    (FETCH_DATA),
    .offset  (FETCH_OFFSET),
    .pc      (FETCH_PC),
    .len     (dec.len),
    .taken   (taken),
    .target  (target)
  );

  // Next outputs and flags
  always_comb begin
    valid_next   = FETCH_VALID;
    dec_next     = dec_reg;
    taken_next   = 1'b0;
    target_next  = target_reg;
    result_next  = result_reg;
    product_next = product_reg;
    bad_next     = bad_reg;
    ccr_next     = ccr_reg;
    if (ALU_VALID) begin
      ccr_next.h = low_sum[4];             // see RL20
    end
    if (FETCH_VALID) begin
      dec_next    = dec;
      bad_next    = bad;
      target_next = target;
      unique case (dec.cls)
        CL_JUMP, CL_BIT_TEST: begin
          taken_next = taken;              // see RL1, see RL8
          if (dec.cls == CL_BIT_TEST) begin
            ccr_next.c = FETCH_DATA[FETCH_OPCODE[3:1]];
          end
        end
        CL_CALL: taken_next = 1'b1;        // see RL7
        CL_BIT_SET: begin
          result_next = FETCH_OPCODE[0] ? (FETCH_DATA & ~bit_mask)
                                        : (FETCH_DATA | bit_mask); // see RL10
        end
        CL_RMW: begin
          result_next = res;               // see RL22
          ccr_next.n  = res[7];
          ccr_next.z  = (res == 8'h00);
          ccr_next.c  = c_out;
        end
        CL_PRODUCT: begin
          product_next = {8'h00, ACC_IN} * {8'h00, IDX_IN}; // see RL19
          ccr_next.h   = 1'b0;             // see RL19
          ccr_next.c   = 1'b0;             // see RL19
        end
        CL_CTRL: begin
          unique case (dec.ctrl)
            CT_SET_CARRY:   ccr_next.c = 1'b1;  // see RL15
            CT_CLEAR_CARRY: ccr_next.c = 1'b0;  // see RL15
            CT_MASK:        ccr_next.i = 1'b1;  // see RL16
            CT_UNMASK:      ccr_next.i = 1'b0;  // see RL16
            default:        ccr_next.i = ccr_reg.i;
          endcase
        end
        CL_TRAP: ccr_next.i = 1'b1;        // Trap entry masks interrupts
        default: taken_next = 1'b0;
      endcase
    end
  end

  // Output and flag registers
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      valid_reg   <= 1'b0;
      dec_reg     <= '0;
      taken_reg   <= 1'b0;
      target_reg  <= '0;
      result_reg  <= 8'h00;
      product_reg <= 16'h0000;
      ccr_reg     <= CCR_RESET;
      bad_reg     <= 1'b0;
    end else begin
      valid_reg   <= valid_next;
      dec_reg     <= dec_next;
      taken_reg   <= taken_next;
      target_reg  <= target_next;
      result_reg  <= result_next;
      product_reg <= product_next;
      ccr_reg     <= ccr_next;
      bad_reg     <= bad_next;
    end
  end

  // Ports straight from registers
  assign DEC_VALID   = valid_reg;
  assign DEC_INFO    = dec_reg;
  assign JUMP_TAKEN  = taken_reg;
  assign JUMP_TARGET = target_reg;
  assign RESULT      = result_reg;
  assign PRODUCT     = product_reg;
  assign CCR         = ccr_reg;
  assign UNHANDLED   = bad_reg;

endmodule : cbrd_decoder

// >>> dv/cbrd_prog_mem.sv
// Program memory model
module cbrd_prog_mem (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic [15:0] pc,
  output logic             valid,
  output logic [7:0]       opcode,
  output logic [7:0]       offset,
  output logic [7:0]       data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [256];
  logic [7:0]  dmem [256];
  logic [7:0]  op_b, off_b, dat_b;
  logic [23:0] last_reg = 24'h000000;
  // Bytes at pc; bit-test offset comes third
  always_comb begin
    op_b  = mem[pc[7:0]];
    off_b = mem[pc[7:0] + ((op_b[7:4] == 4'h0) ? 8'h02 : 8'h01)];
    dat_b = dmem[mem[pc[7:0] + 8'h01]];
  end
  // Last bytes shown
  always_ff @(posedge clk) if (req) last_reg <= {op_b, off_b, dat_b};
  // Idle bus shows the last bytes inverted
  assign valid = req;
  assign {opcode, offset, data} = req ? {op_b, off_b, dat_b} : ~last_reg;
endmodule : cbrd_prog_mem

// >>> dv/cbrd_decoder_sva.sv
// Assertions on decoder ports
module cbrd_decoder_sva
  import cbrd_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic              MCLK,
  input wire logic              RST_N,
  input wire logic              FETCH_VALID,
  input wire logic [7:0]        FETCH_OPCODE,
  input wire logic [ADDR_W-1:0] FETCH_PC,
  input wire logic [7:0]        FETCH_OFFSET,
  input wire logic [7:0]        ACC_IN,
  input wire logic [7:0]        IDX_IN,
  input wire logic              IRQ_PIN,
  input wire logic              ALU_VALID,
  input wire logic [7:0]        ALU_A,
  input wire logic [7:0]        ALU_B,
  input wire logic              ALU_CIN,
  input wire logic              DEC_VALID,
  input wire cbrd_dec_t         DEC_INFO,
  input wire logic              JUMP_TAKEN,
  input wire logic [ADDR_W-1:0] JUMP_TARGET,
  input wire logic [15:0]       PRODUCT,
  input wire cbrd_ccr_t         CCR
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0]        fop;
  logic [4:0]        hsum;
  logic [ADDR_W-1:0] tgt_exp;
  logic [15:0]       prod_exp;
  // Qualified opcode, expected values
  assign fop      = {FETCH_VALID, FETCH_OPCODE};
  assign hsum     = ALU_A[3:0] + ALU_B[3:0] + ALU_CIN;
  assign tgt_exp  = FETCH_PC + ADDR_W'(2)
                  + {{(ADDR_W-8){FETCH_OFFSET[7]}}, FETCH_OFFSET};
  assign prod_exp = ACC_IN * IDX_IN;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  jump_len_a: assert property (fop[8:4] == 5'h12 |=> DEC_VALID
    && DEC_INFO.len == 2'h2 && DEC_INFO.cycles == 4'h3)
    else $error("jump length wrong");
  always_never_a: assert property (fop inside {9'h120, 9'h121}
    |=> JUMP_TAKEN == !$past(FETCH_OPCODE[0]))
    else $error("always or never jump wrong");
  zero_jump_a: assert property (fop == 9'h127
    |=> JUMP_TAKEN == $past(CCR.z)) else $error("zero jump wrong");
  mask_jump_a: assert property (fop == 9'h12D
    |=> JUMP_TAKEN == $past(CCR.i)) else $error("mask jump wrong");
  pin_jump_a: assert property (fop == 9'h12F
    |=> JUMP_TAKEN == $past(IRQ_PIN)) else $error("pin jump wrong");
  call_len_a: assert property (fop == 9'h1AD |=> JUMP_TAKEN
    && DEC_INFO.len == 2'h2 && DEC_INFO.cycles == 4'h6)
    else $error("relative call wrong");
  bit_test_a: assert property (fop[8:4] == 5'h10 |=>
    DEC_INFO.len == 2'h3 && DEC_INFO.cycles == 4'h5)
    else $error("bit test length wrong");
  jump_target_a: assert property (fop[8:4] == 5'h12
    |=> JUMP_TARGET == $past(tgt_exp)) else $error("jump target wrong");
  product_flags_a: assert property (fop == 9'h142 |=> PRODUCT ==
    $past(prod_exp) && !CCR.h && !CCR.c && DEC_INFO.cycles == 4'hB)
    else $error("multiply wrong");
  mask_bit_a: assert property (fop inside {9'h19A, 9'h19B}
    |=> CCR.i == $past(FETCH_OPCODE[0])) else $error("mask bit wrong");
  half_carry_a: assert property (ALU_VALID && !FETCH_VALID
    |=> CCR.h == $past(hsum[4])) else $error("half carry wrong");
  test_only_a: assert property (FETCH_VALID &&
    FETCH_OPCODE[3:0] == 4'hD && FETCH_OPCODE[7:4] inside {[4'h3:4'h7]}
    |=> !DEC_INFO.write_back) else $error("test op writes back");

  // Main scenarios reached
  taken_c: cover property (DEC_VALID && JUMP_TAKEN);
  product_c: cover property (fop == 9'h142 && ALU_VALID);
  half_c: cover property (ALU_VALID && hsum[4]);
endmodule : cbrd_decoder_sva

bind cbrd_decoder cbrd_decoder_sva #(.ADDR_W(ADDR_W)) i_cbrd_decoder_sva (
  .MCLK(MCLK), .RST_N(RST_N), .FETCH_VALID(FETCH_VALID),
  .FETCH_OPCODE(FETCH_OPCODE), .FETCH_PC(FETCH_PC),
  .FETCH_OFFSET(FETCH_OFFSET), .ACC_IN(ACC_IN), .IDX_IN(IDX_IN),
  .IRQ_PIN(IRQ_PIN), .ALU_VALID(ALU_VALID), .ALU_A(ALU_A), .ALU_B(ALU_B),
  .ALU_CIN(ALU_CIN), .DEC_VALID(DEC_VALID), .DEC_INFO(DEC_INFO),
  .JUMP_TAKEN(JUMP_TAKEN), .JUMP_TARGET(JUMP_TARGET), .PRODUCT(PRODUCT),
  .CCR(CCR));

// >>> dv/cbrd_decoder_test.sv
// Self-checking bench for the decoder
module cbrd_decoder_test
  import cbrd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        MCLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        req = 1'b0, irq = 1'b0, alu_v = 1'b0, alu_c = 1'b0;
  logic [15:0] pc = 16'h0000;
  logic [7:0]  acc = 8'h00, idx = 8'h00, alu_a = 8'h00, alu_b = 8'h01;
  logic [7:0]  f_op, f_off, f_dat, res;
  logic        f_v, dv, jt, unh;
  logic [15:0] tgt, prod;
  cbrd_dec_t   dec;
  cbrd_ccr_t   ccr;
  int          mismatches = 0;
  int          check_count = 0;
  logic [31:0] lfsr_reg = 32'h85F9BCEA;
  logic [3:0]  rmw_lo [11] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9,
                               4'hA, 4'hC, 4'hD, 4'hF};

  cbrd_prog_mem i_cbrd_prog_mem (.clk(MCLK), .req(req), .pc(pc),
    .valid(f_v), .opcode(f_op), .offset(f_off), .data(f_dat));
  cbrd_decoder i_cbrd_decoder (.MCLK(MCLK), .RST_N(RST_N),
    .FETCH_VALID(f_v), .FETCH_OPCODE(f_op), .FETCH_PC(pc),
    .FETCH_OFFSET(f_off), .FETCH_DATA(f_dat), .ACC_IN(acc), .IDX_IN(idx),
    .IRQ_PIN(irq), .ALU_VALID(alu_v), .ALU_A(alu_a), .ALU_B(alu_b),
    .ALU_CIN(alu_c), .DEC_VALID(dv), .DEC_INFO(dec), .JUMP_TAKEN(jt),
    .JUMP_TARGET(tgt), .RESULT(res), .PRODUCT(prod), .CCR(ccr),
    .UNHANDLED(unh));

  // Clock at 4 ns
  initial forever #2 MCLK = ~MCLK;

  function automatic logic [7:0] rnd();
    lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1]
                ^ lfsr_reg[0]};
    return lfsr_reg[7:0];
  endfunction : rnd

  // Expected {length, cycles}; zero if not decoded
  function automatic logic [5:0] exp_lc(input logic [7:0] op);
    logic t, ok;
    t  = op[3:0] == 4'hD;
    ok = op[3:0] inside {rmw_lo};
    case (op[7:4])
      4'h0: return {2'h3, 4'h5};
      4'h1: return {2'h2, 4'h5};
      4'h2: return {2'h2, 4'h3};
      4'h3: return ok ? {2'h2, t ? 4'h4 : 4'h5} : 6'h00;
      4'h4: return op == 8'h42 ? {2'h1, 4'hB} : ok ? 6'h13 : 6'h00;
      4'h5: return ok ? 6'h13 : 6'h00;
      4'h6: return ok ? {2'h2, t ? 4'h5 : 4'h6} : 6'h00;
      4'h7: return ok ? {2'h1, t ? 4'h4 : 4'h5} : 6'h00;
      default: ;
    endcase
    case (op)
      8'hAD: return {2'h2, 4'h6};
      8'h81: return {2'h1, 4'h6};
      8'h80: return {2'h1, 4'h9};
      8'h83: return {2'h1, 4'hA};
      8'h97, 8'h9F, 8'h99, 8'h98, 8'h9B, 8'h9A, 8'h9C, 8'h9D, 8'h8E,
      8'h8F: return {2'h1, 4'h2};
      default: return 6'h00;
    endcase
  endfunction : exp_lc

  // Rmw result by low nibble
  function automatic logic [7:0] exp_rmw(input logic [3:0] lo,
                                         input logic [7:0] v, input logic c);
    case (lo)
      4'h0: return 8'h00 - v;
      4'h3: return ~v;
      4'h4: return {1'b0, v[7:1]};
      4'h6: return {c, v[7:1]};
      4'h7: return {v[7], v[7:1]};
      4'h8: return {v[6:0], 1'b0};
      4'h9: return {v[6:0], c};
      4'hA: return v - 8'h01;
      4'hC: return v + 8'h01;
      4'hF: return 8'h00;
      default: return v;
    endcase
  endfunction : exp_rmw

  // Jump condition {pin, i, n, h, z, c, c|z, never}; odd opcode tests true
  function automatic logic exp_jump(input logic [7:0] op,
                                    input cbrd_ccr_t f, input logic pin);
    logic [7:0] cond;
    cond = {pin, f.i, f.n, f.h, f.z, f.c, f.c | f.z, 1'b0};
    return op[0] ? cond[op[3:1]] : !cond[op[3:1]];
  endfunction : exp_jump

  task automatic chk(input string nm, input logic [31:0] e, s);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk

  // Present one instruction; strobe left up
  task automatic issue(input logic [7:0] op, b1, b2, input logic [15:0] a);
    i_cbrd_prog_mem.mem[a[7:0]] = op;
    i_cbrd_prog_mem.mem[a[7:0] + 8'h01] = b1;
    i_cbrd_prog_mem.mem[a[7:0] + 8'h02] = b2;
    pc = a;
    req = 1'b1;
    @(posedge MCLK);
    #1;
  endtask : issue

  // Idle cycle, optional ALU result
  task automatic idle(input logic v, input logic [7:0] x);
    req = 1'b0;
    alu_v = v;
    alu_a = x;
    alu_c = rnd() > 8'h7F;
    @(posedge MCLK);
    #1;
    alu_v = 1'b0;
  endtask : idle

  task automatic wrap_up();
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    logic [7:0]  op, v, ad, o, r;
    logic [15:0] a;
    cbrd_ccr_t   fl;
    repeat (8) @(posedge MCLK);
    #1;
    RST_N = 1'b1;
    chk("ccr_reset", 5'h04, ccr);
    // Two flag sets, then all relative jumps
    for (int s = 0; s < 2; s++) begin
      acc = s ? 8'h80 : 8'h00;
      issue(s ? 8'h99 : 8'h98, 8'h00, 8'h00, 16'h0010);
      issue(s ? 8'h9B : 8'h9A, 8'h00, 8'h00, 16'h0010);
      issue(s ? 8'h4D : 8'h4F, 8'h00, 8'h00, 16'h0010);
      idle(1'b1, s ? 8'h00 : 8'h0F);
      fl = s ? 5'b01101 : 5'b10010;
      chk("flags", fl, ccr);
      for (int k = 0; k < 16; k++) begin
        a = {rnd(), rnd()};
        o = rnd();
        irq = lfsr_reg[9];
        op = 8'h20 + 8'(k);
        issue(op, o, 8'h00, a);
        chk("taken", exp_jump(op, fl, irq), jt);
        chk("target", 16'(a + 16'h2 + {{8{o[7]}}, o}), tgt);
      end
    end
    // Rmw on acc and direct byte, carry set
    foreach (rmw_lo[j]) for (int m = 0; m < 2; m++) begin
      v = rnd();
      ad = rnd();
      acc = v;
      i_cbrd_prog_mem.dmem[ad] = v;
      issue(8'h99, 8'h00, 8'h00, 16'h0030);
      issue({m ? 4'h3 : 4'h4, rmw_lo[j]}, ad, 8'h00, 16'h0020);
      r = exp_rmw(rmw_lo[j], v, 1'b1);
      if (rmw_lo[j] != 4'hD) chk("result", r, res);
      chk("nz", {r[7], r == 8'h00}, {ccr.n, ccr.z});
    end
    // Multiply with a same-cycle ALU result
    for (int k = 0; k < 4; k++) begin
      acc = rnd();
      idx = rnd();
      issue(8'h99, 8'h00, 8'h00, 16'h0040);
      alu_a = 8'h0F;
      alu_v = 1'b1;
      issue(8'h42, 8'h00, 8'h00, 16'h0048);
      alu_v = 1'b0;
      chk("product", 16'(acc) * 16'(idx), prod);
      chk("h_c", 2'b00, {ccr.h, ccr.c});
    end
    // Bit set/clear and bit test jumps
    for (int n = 0; n < 16; n++) begin
      v = rnd();
      ad = rnd();
      o = rnd();
      a = {rnd(), rnd()};
      i_cbrd_prog_mem.dmem[ad] = v;
      issue(8'h10 + 8'(n), ad, 8'h00, a);
      r = n[0] ? v & ~(8'h01 << n[3:1]) : v | (8'h01 << n[3:1]);
      chk("bit_result", r, res);
      issue(8'(n), ad, o, a);
      chk("bit_taken", v[n[3:1]] ^ n[0], jt);
      chk("bit_target", 16'(a + 16'h3 + {{8{o[7]}}, o}), tgt);
    end
    // All opcodes back to back
    for (int k = 0; k < 256; k++) begin
      op = 8'(k);
      acc = rnd();
      idx = rnd();
      issue(op, rnd(), rnd(), {rnd(), rnd()});
      chk("unhandled", exp_lc(op) == 6'h00, unh);
      if (exp_lc(op) != 6'h00)
        chk("len_cyc", exp_lc(op), dec[6:1]);
    end
    RST_N = 1'b0;
    @(posedge MCLK);
    #1;
    RST_N = 1'b1;
    chk("ccr_rst2", 5'h04, ccr);
    chk("valid_rst2", 1'b0, dv);
    wrap_up();
  end

  // Hang guard
  initial begin
    #80000;
    mismatches++;
    wrap_up();
  end
endmodule : cbrd_decoder_test
